// file: hw/tcc_pkg.sv
// Package of constants, register map and carrier types for the timer capture/compare unit.
package tcc_pkg;

   localparam int CNT_W = 16;
   localparam int ADDR_W = 8;
   localparam int NCH = 2;

   typedef logic [CNT_W-1:0] tcc_count_t;
   typedef logic [ADDR_W-1:0] tcc_addr_t;

   localparam tcc_count_t COUNT_ZERO = 16'h0000;
   localparam tcc_count_t COUNT_ONE = 16'h0001;
   localparam tcc_count_t COUNT_MAX = 16'hFFFF;

   // Register offsets, one aligned word each.
   localparam tcc_addr_t ADDR_CTRL0 = 8'h00;
   localparam tcc_addr_t ADDR_CTRL1 = 8'h04;
   localparam tcc_addr_t ADDR_EDGE = 8'h08;
   localparam tcc_addr_t ADDR_SRC = 8'h0C;
   localparam tcc_addr_t ADDR_CC0 = 8'h10;
   localparam tcc_addr_t ADDR_CC1 = 8'h14;
   localparam tcc_addr_t ADDR_COUNT = 8'h18;
   localparam tcc_addr_t ADDR_STATUS = 8'h1C;

   // Control word 0 fields.
   localparam int ACT_BIT = 0;
   localparam int CE_BIT = 1;
   localparam int CS_LO = 2;
   localparam int CS_HI = 3;

   // Control word 1 fields.
   localparam int MODE0_BIT = 0;
   localparam int MODE1_BIT = 1;
   localparam int CLR_BIT = 3;
   localparam int ALV_BIT = 5;
   localparam int OE_BIT = 6;

   localparam int SRC_BIT = 0;
   localparam int OVF_BIT = 0;
   localparam int EDGE_W = 2;

   // Edge select codes; the remaining code is prohibited and detects nothing.
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   localparam logic ALV_RESET = 1'b1;
   localparam int DIV_W = 3;
   localparam logic [DIV_W-1:0] DIV_ONE = 3'h1;

   typedef struct packed {
      logic oe;
      logic output_active_level;
      logic clr;
      logic mode1;
      logic mode0;
   } tcc_ctrl_t;

   typedef struct packed {
      tcc_addr_t addr;
      tcc_count_t wdata;
      logic we;
      logic re;
   } tcc_req_t;

endpackage : tcc_pkg

// file: hw/tcc_trig_edge.sv
// Trigger synchroniser and selectable edge detector for one capture channel.
`timescale 1ns/100ps
`default_nettype none
module tcc_trig_edge (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Trigger and edge choice
   input wire logic trig_async,
   input wire logic [1:0] edge_sel,
   // Detected edge
   output logic edge_pulse
);

   logic sync1_q;
   logic sync2_q;
   logic prev_q;
   logic pulse_q;
   logic rise;
   logic fall;
   logic hit;

   // Only the second stage and the edge history look at synchronised data.
   assign rise = sync2_q & ~prev_q;
   assign fall = ~sync2_q & prev_q;
   assign hit = (edge_sel == tcc_pkg::EDGE_RISE) ? rise :
                (edge_sel == tcc_pkg::EDGE_FALL) ? fall :
                (edge_sel == tcc_pkg::EDGE_BOTH) ? (rise | fall) : 1'b0;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q <= 1'b0;
         pulse_q <= 1'b0;
      end else begin
         sync1_q <= trig_async;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
         pulse_q <= hit;
      end
   end

   assign edge_pulse = pulse_q;

endmodule : tcc_trig_edge
`default_nettype wire

// file: hw/tcc_timer.sv
// Timer with 16-bit free-running counter and two capture/compare channels.
// Function
// - A 16-bit up-counter runs freely and wraps from its maximum to zero.
// - Wrap from FFFFH to 0000H sets overflow flag and overflow interrupt together.
// - Channel 0 compare FFFFH with match clearing makes the wrap a clear, no overflow.
// - Count enable falling returns the counter to zero without any overflow.
// - Each channel has a mode bit: 0 capture, 1 compare.
// - Capture latches the count on each valid trigger edge and holds it.
// - Every valid capture edge raises that channel's interrupt.
// - Each channel's valid edge is chosen by its own two-bit field.
// - A selector picks pin triggers or the CAN frame start signal.
// - No capture happens while count enable is zero.
// - A compare match changes the pulse output and raises the channel interrupt.
// - Matches are judged on the new count right after each step; a channel 0 clearing match is judged on the count before it.
// - Without match clearing, channel 0 compare 0000H matches only after a wrap, not at start.
// - Match clearing with channel 0 in compare mode clears the counter on match.
// - Interval mode clears to 0000H on match, period is compare plus one.
// - Edge codes are 00 falling, 01 rising, 11 both; 10 detects nothing.
// - Channel 0 match drives output active, channel 1 match drives it inactive.
// - With output enable zero the pulse output holds the inactive level.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module tcc_timer (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [15:0] reg_rdata,
   // Trigger sources
   input wire logic channel0_trigger_input,
   input wire logic channel1_trigger_input,
   input wire logic can_frame_start_signal,
   // Pulse pin and events
   output logic pulse_output,
   output logic overflow_flag,
   output logic overflow_irq,
   output logic channel0_irq,
   output logic channel1_irq
);

   tcc_pkg::tcc_req_t req;
   logic counter_activation_q;
   logic count_enable_q;
   logic [1:0] clk_sel_q;
   tcc_pkg::tcc_ctrl_t ctrl_q;
   logic [3:0] edge_select_register_q;
   logic trigger_source_select_q;
   tcc_pkg::tcc_count_t main_counter_q;
   tcc_pkg::tcc_count_t main_counter_d;
   tcc_pkg::tcc_count_t cc_q [tcc_pkg::NCH];
   logic overflow_flag_q;
   logic overflow_irq_q;
   logic [tcc_pkg::NCH-1:0] irq_q;
   logic out_active_q;
   logic pulse_q;
   logic [15:0] rdata_q;
   logic [tcc_pkg::DIV_W-1:0] div_q;

   assign req = '{addr: reg_addr, wdata: reg_wdata, we: reg_we, re: reg_re};

   function automatic logic f_hit(input tcc_pkg::tcc_addr_t a, input tcc_pkg::tcc_addr_t t);
      f_hit = (a == t);
   endfunction : f_hit

   // Write decode.
   logic wr_ctrl0;
   logic wr_ctrl1;
   logic wr_edge;
   logic wr_src;
   logic wr_status;
   logic [tcc_pkg::NCH-1:0] wr_cc;
   assign wr_ctrl0 = req.we && f_hit(req.addr, tcc_pkg::ADDR_CTRL0);
   assign wr_ctrl1 = req.we && f_hit(req.addr, tcc_pkg::ADDR_CTRL1);
   assign wr_edge = req.we && f_hit(req.addr, tcc_pkg::ADDR_EDGE);
   assign wr_src = req.we && f_hit(req.addr, tcc_pkg::ADDR_SRC);
   assign wr_status = req.we && f_hit(req.addr, tcc_pkg::ADDR_STATUS);
   assign wr_cc[0] = req.we && f_hit(req.addr, tcc_pkg::ADDR_CC0);
   assign wr_cc[1] = req.we && f_hit(req.addr, tcc_pkg::ADDR_CC1);

   // Count clock: a one-cycle enable from a divider of 1, 2, 4 or 8.
   logic [tcc_pkg::DIV_W-1:0] div_mask;
   logic div_tick;
   logic count_en;
   assign div_mask = tcc_pkg::DIV_W'((tcc_pkg::DIV_ONE << clk_sel_q) - tcc_pkg::DIV_ONE);
   assign div_tick = ((div_q & div_mask) == div_mask);
   assign count_en = counter_activation_q & count_enable_q & div_tick;

   // Compare logic, judged on the value the counter is about to take; clearing is judged on its present value.
   logic [tcc_pkg::NCH-1:0] mode_cmp;
   logic clear0;
   logic wrap;
   tcc_pkg::tcc_count_t next_cnt;
   tcc_pkg::tcc_count_t new_cnt;
   logic [tcc_pkg::NCH-1:0] match;
   logic ovf_set;
   assign mode_cmp = {ctrl_q.mode1, ctrl_q.mode0};
   assign next_cnt = main_counter_q + tcc_pkg::COUNT_ONE;
   assign wrap = count_en && (main_counter_q == tcc_pkg::COUNT_MAX);
   // Clearing waits one step after reaching the compare value so the interval is p + 1.
   assign clear0 = count_en && mode_cmp[0] && ctrl_q.clr && (main_counter_q == cc_q[0]);
   assign new_cnt = clear0 ? tcc_pkg::COUNT_ZERO : next_cnt;
   // A match on channel 0 with clearing is the clear itself, raised as counting resumes.
   assign match[0] = ctrl_q.clr ? clear0 :
                     (count_en && mode_cmp[0] && (new_cnt == cc_q[0]));
   assign match[1] = count_en && mode_cmp[1] && (new_cnt == cc_q[1]);
   assign ovf_set = wrap && !clear0;

   always_comb begin
      main_counter_d = main_counter_q;
      if (!counter_activation_q || !count_enable_q) begin
         main_counter_d = tcc_pkg::COUNT_ZERO;
      end else if (count_en) begin
         main_counter_d = new_cnt;
      end
   end

   // Trigger paths; every source is synchronised before the source choice looks at it.
   logic [tcc_pkg::NCH-1:0] pin_trig;
   logic [tcc_pkg::NCH-1:0] pin_hit;
   logic [tcc_pkg::NCH-1:0] can_hit;
   logic [tcc_pkg::NCH-1:0] edge_hit;
   logic [tcc_pkg::NCH-1:0] capture;
   assign pin_trig[0] = channel0_trigger_input;
   assign pin_trig[1] = channel1_trigger_input;

   genvar gi;
   generate
      for (gi = 0; gi < tcc_pkg::NCH; gi++) begin : g_ch
         tcc_trig_edge u_edge (
            .clk(clk),
            .rst_b(rst_b),
            .trig_async(pin_trig[gi]),
            .edge_sel(edge_select_register_q[gi*tcc_pkg::EDGE_W +: tcc_pkg::EDGE_W]),
            .edge_pulse(pin_hit[gi])
         );
         // Choosing between two synchronised edge streams cannot invent an edge on a switch.
         tcc_trig_edge u_can_edge (
            .clk(clk),
            .rst_b(rst_b),
            .trig_async(can_frame_start_signal),
            .edge_sel(edge_select_register_q[gi*tcc_pkg::EDGE_W +: tcc_pkg::EDGE_W]),
            .edge_pulse(can_hit[gi])
         );
         assign edge_hit[gi] = trigger_source_select_q ? can_hit[gi] : pin_hit[gi];
         assign capture[gi] = edge_hit[gi] && counter_activation_q && count_enable_q
                              && !mode_cmp[gi];

         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               cc_q[gi] <= tcc_pkg::COUNT_ZERO;
               irq_q[gi] <= 1'b0;
            end else begin
               // A capture wins over a software write in the same cycle.
               if (capture[gi]) begin
                  cc_q[gi] <= main_counter_q;
               end else if (wr_cc[gi]) begin
                  cc_q[gi] <= req.wdata;
               end
               irq_q[gi] <= capture[gi] | match[gi];
            end
         end
      end
   endgenerate

   // Pulse output control.
   logic out_active_d;
   logic pulse_d;
   assign out_active_d = !ctrl_q.oe ? 1'b0 :
                         match[1] ? 1'b0 :
                         match[0] ? 1'b1 : out_active_q;
   assign pulse_d = out_active_d ? ctrl_q.output_active_level : ~ctrl_q.output_active_level;

   // Read data selection.
   logic [15:0] rd_d;
   assign rd_d = !req.re ? 16'h0000 :
      f_hit(req.addr, tcc_pkg::ADDR_CTRL0) ?
         {12'h000, clk_sel_q, count_enable_q, counter_activation_q} :
      f_hit(req.addr, tcc_pkg::ADDR_CTRL1) ?
         {9'h000, ctrl_q.oe, ctrl_q.output_active_level, 1'b0, ctrl_q.clr, 1'b0, ctrl_q.mode1, ctrl_q.mode0} :
      f_hit(req.addr, tcc_pkg::ADDR_EDGE) ? {12'h000, edge_select_register_q} :
      f_hit(req.addr, tcc_pkg::ADDR_SRC) ? {15'h0000, trigger_source_select_q} :
      f_hit(req.addr, tcc_pkg::ADDR_CC0) ? cc_q[0] :
      f_hit(req.addr, tcc_pkg::ADDR_CC1) ? cc_q[1] :
      f_hit(req.addr, tcc_pkg::ADDR_COUNT) ? main_counter_q :
      f_hit(req.addr, tcc_pkg::ADDR_STATUS) ? {15'h0000, overflow_flag_q} : 16'h0000;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         counter_activation_q <= 1'b0;
         count_enable_q <= 1'b0;
         clk_sel_q <= 2'h0;
      end else if (wr_ctrl0) begin
         counter_activation_q <= req.wdata[tcc_pkg::ACT_BIT];
         count_enable_q <= req.wdata[tcc_pkg::CE_BIT];
         clk_sel_q <= req.wdata[tcc_pkg::CS_HI:tcc_pkg::CS_LO];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= '{oe: 1'b0, output_active_level: tcc_pkg::ALV_RESET, clr: 1'b0, mode1: 1'b0, mode0: 1'b0};
         edge_select_register_q <= 4'h0;
         trigger_source_select_q <= 1'b0;
      end else begin
         if (wr_ctrl1) begin
            ctrl_q.oe <= req.wdata[tcc_pkg::OE_BIT];
            ctrl_q.output_active_level <= req.wdata[tcc_pkg::ALV_BIT];
            ctrl_q.clr <= req.wdata[tcc_pkg::CLR_BIT];
            ctrl_q.mode1 <= req.wdata[tcc_pkg::MODE1_BIT];
            ctrl_q.mode0 <= req.wdata[tcc_pkg::MODE0_BIT];
         end
         if (wr_edge) begin
            edge_select_register_q <= req.wdata[tcc_pkg::NCH*tcc_pkg::EDGE_W-1:0];
         end
         if (wr_src) begin
            trigger_source_select_q <= req.wdata[tcc_pkg::SRC_BIT];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         main_counter_q <= tcc_pkg::COUNT_ZERO;
         div_q <= '0;
         overflow_flag_q <= 1'b0;
         overflow_irq_q <= 1'b0;
         out_active_q <= 1'b0;
         pulse_q <= ~tcc_pkg::ALV_RESET;
         rdata_q <= 16'h0000;
      end else begin
         main_counter_q <= main_counter_d;
         div_q <= counter_activation_q ? div_q + tcc_pkg::DIV_ONE : '0;
         // A new overflow wins over a write-one clear in the same cycle.
         overflow_flag_q <= ovf_set |
            (overflow_flag_q & ~(wr_status & req.wdata[tcc_pkg::OVF_BIT]));
         overflow_irq_q <= ovf_set;
         out_active_q <= out_active_d;
         pulse_q <= pulse_d;
         rdata_q <= rd_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign pulse_output = pulse_q;
   assign overflow_flag = overflow_flag_q;
   assign overflow_irq = overflow_irq_q;
   assign channel0_irq = irq_q[0];
   assign channel1_irq = irq_q[1];

   // Checks on the block's own behaviour.
   property p_wrap_ovf;
      @(posedge clk) disable iff (!rst_b)
      (count_en && main_counter_q == tcc_pkg::COUNT_MAX && !clear0)
         |=> (main_counter_q == tcc_pkg::COUNT_ZERO) && overflow_irq && overflow_flag;
   endproperty
   a_wrap_ovf: assert property (p_wrap_ovf) else $error("wrap without overflow");

   property p_clear_no_ovf;
      @(posedge clk) disable iff (!rst_b)
      clear0 |=> !overflow_irq && (main_counter_q == tcc_pkg::COUNT_ZERO);
   endproperty
   a_clear_no_ovf: assert property (p_clear_no_ovf) else $error("clear raised overflow");

   property p_ce_off;
      @(posedge clk) disable iff (!rst_b)
      !count_enable_q |=> (main_counter_q == tcc_pkg::COUNT_ZERO) && !overflow_irq;
   endproperty
   a_ce_off: assert property (p_ce_off) else $error("disabled counter not cleared");

   property p_capture;
      @(posedge clk) disable iff (!rst_b)
      capture[0] |=> (cc_q[0] == $past(main_counter_q)) && channel0_irq;
   endproperty
   a_capture: assert property (p_capture) else $error("capture value or irq wrong");

   property p_cap_irq1;
      @(posedge clk) disable iff (!rst_b)
      (edge_hit[1] && count_enable_q && counter_activation_q && !ctrl_q.mode1) |=> channel1_irq;
   endproperty
   a_cap_irq1: assert property (p_cap_irq1) else $error("capture irq missing");

   property p_no_cap_off;
      @(posedge clk) disable iff (!rst_b)
      (!count_enable_q && !wr_cc[0]) |=> !channel0_irq && $stable(cc_q[0]);
   endproperty
   a_no_cap_off: assert property (p_no_cap_off) else $error("capture while disabled");

   property p_match1_out;
      @(posedge clk) disable iff (!rst_b)
      (match[1] && ctrl_q.oe && !wr_ctrl1) |=> channel1_irq && (pulse_output == !ctrl_q.output_active_level);
   endproperty
   a_match1_out: assert property (p_match1_out) else $error("match 1 output wrong");

   property p_match0_out;
      @(posedge clk) disable iff (!rst_b)
      (match[0] && !match[1] && ctrl_q.oe && !wr_ctrl1) |=> channel0_irq && (pulse_output == ctrl_q.output_active_level);
   endproperty
   a_match0_out: assert property (p_match0_out) else $error("match 0 output wrong");

   property p_oe_off;
      @(posedge clk) disable iff (!rst_b)
      (!ctrl_q.oe && !wr_ctrl1) |=> (pulse_output == !ctrl_q.output_active_level);
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("disabled output not inactive");

   property p_step;
      @(posedge clk) disable iff (!rst_b)
      (count_en && !clear0) |=> (main_counter_q == $past(main_counter_q) + tcc_pkg::COUNT_ONE);
   endproperty
   a_step: assert property (p_step) else $error("counter did not step");

   c_wrap: cover property (@(posedge clk) disable iff (!rst_b) ovf_set);
   c_capture: cover property (@(posedge clk) disable iff (!rst_b) capture[1]);
   c_clear: cover property (@(posedge clk) disable iff (!rst_b) clear0 ##1 count_en);
   c_pwm: cover property (@(posedge clk) disable iff (!rst_b) match[0] ##[1:200] match[1]);

endmodule : tcc_timer
`default_nettype wire

// file: dv/tcc_far_model.sv
// Model of the trigger sources and of the load on the pulse pin.
`timescale 1ns/100ps
`default_nettype none
module tcc_far_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Levels asked for by the bench
   input wire logic want0,
   input wire logic want1,
   input wire logic want_can,
   // Source pins toward the timer
   output logic channel0_trigger_input,
   output logic channel1_trigger_input,
   output logic can_frame_start_signal,
   // Pulse pin load
   input wire logic pulse_output,
   output logic [15:0] pulse_rises
);
   logic pulse_q;
   // Sources are always driven; each level is held long enough to pass the synchroniser.
   // The bench spaces captures well inside one counter wrap.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         channel0_trigger_input <= 1'b0;
         channel1_trigger_input <= 1'b0;
         can_frame_start_signal <= 1'b0;
         pulse_q <= 1'b0;
         pulse_rises <= 16'h0000;
      end else begin
         channel0_trigger_input <= want0;
         channel1_trigger_input <= want1;
         can_frame_start_signal <= want_can;
         pulse_q <= pulse_output;
         if (pulse_output && !pulse_q) begin
            pulse_rises <= pulse_rises + 16'h0001;
         end
      end
   end
endmodule : tcc_far_model
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the timer capture/compare unit.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk, rst_b, reg_we, reg_re, w0, w1, wc;
   tcc_pkg::tcc_addr_t reg_addr;
   logic [15:0] reg_wdata, reg_rdata, rises, a, b, v;
   logic pulse_output, overflow_flag, overflow_irq, channel0_irq, channel1_irq;
   logic p0, p1, pc;
   int bad_count, checks, n0, n1, nov, n;
   logic [1:0] codes [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
   logic [15:0] expn [4] = '{16'h0001, 16'h0001, 16'h0002, 16'h0000};

   tcc_timer DUT (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .channel0_trigger_input(p0),
      .channel1_trigger_input(p1), .can_frame_start_signal(pc), .pulse_output(pulse_output),
      .overflow_flag(overflow_flag), .overflow_irq(overflow_irq),
      .channel0_irq(channel0_irq), .channel1_irq(channel1_irq));
   tcc_far_model u_far (.clk(clk), .rst_b(rst_b), .want0(w0), .want1(w1), .want_can(wc),
      .channel0_trigger_input(p0), .channel1_trigger_input(p1), .can_frame_start_signal(pc),
      .pulse_output(pulse_output), .pulse_rises(rises));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (channel0_irq === 1'b1) n0 <= n0 + 1;
      if (channel1_irq === 1'b1) n1 <= n1 + 1;
      if (overflow_irq === 1'b1) nov <= nov + 1;
   end

   function automatic logic pick(input int w);
      case (w)
         0: pick = channel0_irq;
         1: pick = channel1_irq;
         2: pick = overflow_irq;
         3: pick = pulse_output;
         default: pick = ~pulse_output;
      endcase
   endfunction : pick

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(input tcc_pkg::tcc_addr_t ad, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_we <= 1'b1;
      @(posedge clk);
      reg_we <= 1'b0;
   endtask : wr

   task automatic rd(input tcc_pkg::tcc_addr_t ad, output logic [15:0] d);
      @(posedge clk);
      reg_addr <= ad;
      reg_re <= 1'b1;
      @(posedge clk);
      reg_re <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask : rd

   // Counts cycles, sampled mid-cycle, until the chosen signal is high; a hang ends the run.
   task automatic wait_for(input int w, input int bound, output int cnt);
      cnt = 0;
      do begin
         @(negedge clk);
         cnt++;
      end while (pick(w) !== 1'b1 && cnt < bound);
      if (pick(w) !== 1'b1) begin
         chk("wait", {15'h0000, pick(w)}, 16'h0001);
         final_report();
      end
   endtask : wait_for

   task automatic drive(input logic a0, input logic a1, input logic ac);
      @(posedge clk);
      w0 <= a0;
      w1 <= a1;
      wc <= ac;
      repeat (8) @(posedge clk);
   endtask : drive

   task automatic clr_counts;
      @(negedge clk);
      n0 = 0;
      n1 = 0;
      nov = 0;
   endtask : clr_counts

   initial begin
      {reg_we, reg_re, w0, w1, wc} = 5'h00;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      {bad_count, checks, n0, n1, nov} = 0;
      rst_b = 1'b0;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      rd(tcc_pkg::ADDR_CTRL1, v); chk("ctrl1 reset", v, 16'h0020);
      @(negedge clk);
      chk("read data dropped", reg_rdata, 16'h0000);
      rd(tcc_pkg::ADDR_COUNT, v); chk("count idle", v, 16'h0000);
      rd(8'h20, v); chk("unmapped read", v, 16'h0000);
      chk("pulse reset", {15'h0000, pulse_output}, 16'h0000);
      $display("test reset done");
      wr(tcc_pkg::ADDR_CTRL0, 16'h0001);
      wr(tcc_pkg::ADDR_CTRL0, 16'h0003);
      rd(tcc_pkg::ADDR_COUNT, a);
      repeat (5) @(posedge clk);
      rd(tcc_pkg::ADDR_COUNT, b);
      chk("count step", b - a, 16'h0007);
      $display("test count done");
      wr(tcc_pkg::ADDR_CTRL0, 16'h0001);
      wr(tcc_pkg::ADDR_CC0, 16'h0004);
      wr(tcc_pkg::ADDR_CTRL1, 16'h0029);
      wr(tcc_pkg::ADDR_CTRL0, 16'h0003);
      wait_for(0, 100, n);
      wait_for(0, 100, n);
      chk("interval period", n[15:0], 16'h0005);
      $display("test interval done");
      wr(tcc_pkg::ADDR_CTRL0, 16'h0001);
      wr(tcc_pkg::ADDR_CC0, 16'h0000);
      wr(tcc_pkg::ADDR_CTRL1, 16'h0021);
      clr_counts();
      wr(tcc_pkg::ADDR_CTRL0, 16'h0003);
      wait_for(2, 70000, n);
      chk("match at wrap", {15'h0000, channel0_irq}, 16'h0001);
      chk("flag at wrap", {15'h0000, overflow_flag}, 16'h0001);
      chk("no match at start", n0[15:0], 16'h0000);
      wr(tcc_pkg::ADDR_STATUS, 16'h0001);
      @(negedge clk);
      chk("flag cleared", {15'h0000, overflow_flag}, 16'h0000);
      clr_counts();
      wr(tcc_pkg::ADDR_CTRL0, 16'h0001);
      repeat (3) @(posedge clk);
      rd(tcc_pkg::ADDR_COUNT, v); chk("count after stop", v, 16'h0000);
      chk("no overflow at stop", nov[15:0], 16'h0000);
      chk("flag at stop", {15'h0000, overflow_flag}, 16'h0000);
      $display("test overflow done");
      wr(tcc_pkg::ADDR_CTRL1, 16'h0020);
      for (int i = 0; i < 4; i++) begin
         wr(tcc_pkg::ADDR_CTRL0, 16'h0001);
         wr(tcc_pkg::ADDR_EDGE, {12'h000, codes[i], codes[i]});
         wr(tcc_pkg::ADDR_CTRL0, 16'h0003);
         clr_counts();
         drive(1'b1, 1'b1, 1'b0);
         drive(1'b0, 1'b0, 1'b0);
         chk("edge count ch0", n0[15:0], expn[i]);
         chk("edge count ch1", n1[15:0], expn[i]);
      end
      wr(tcc_pkg::ADDR_CTRL0, 16'h0001);
      wr(tcc_pkg::ADDR_EDGE, 16'h0005);
      wr(tcc_pkg::ADDR_CTRL0, 16'h0003);
      @(posedge clk);
      w0 <= 1'b1;
      wait_for(0, 20, n);
      rd(tcc_pkg::ADDR_COUNT, a);
      rd(tcc_pkg::ADDR_CC0, b);
      chk("capture value", b, a - 16'h0002);
      drive(1'b1, 1'b1, 1'b0);
      rd(tcc_pkg::ADDR_CC0, v); chk("capture held", v, b);
      wr(tcc_pkg::ADDR_CTRL0, 16'h0001);
      clr_counts();
      drive(1'b0, 1'b0, 1'b0);
      drive(1'b1, 1'b1, 1'b0);
      chk("no capture irq", n0[15:0], 16'h0000);
      rd(tcc_pkg::ADDR_CC0, v); chk("no capture value", v, b);
      wr(tcc_pkg::ADDR_SRC, 16'h0001);
      wr(tcc_pkg::ADDR_CTRL0, 16'h0003);
      clr_counts();
      drive(1'b0, 1'b0, 1'b1);
      chk("frame start ch0", n0[15:0], 16'h0001);
      chk("frame start ch1", n1[15:0], 16'h0001);
      $display("test capture done");
      wr(tcc_pkg::ADDR_CTRL0, 16'h0001);
      wr(tcc_pkg::ADDR_SRC, 16'h0000);
      wr(tcc_pkg::ADDR_CC0, 16'h000A);
      wr(tcc_pkg::ADDR_CC1, 16'h0014);
      wr(tcc_pkg::ADDR_CTRL1, 16'h0063);
      wr(tcc_pkg::ADDR_CTRL0, 16'h0003);
      wait_for(3, 100, n);
      wait_for(4, 100, n);
      chk("pulse high time", n[15:0], 16'h000A);
      chk("ch1 match irq", {15'h0000, channel1_irq}, 16'h0001);
      chk("pulse rises", rises, 16'h0001);
      wr(tcc_pkg::ADDR_CTRL1, 16'h0003);
      // The pin follows the new control word one cycle after the write lands.
      repeat (2) @(negedge clk);
      chk("pulse disabled", {15'h0000, pulse_output}, 16'h0001);
      $display("test pulse done");
      final_report();
   end
endmodule : testbench
`default_nettype wire
